/* rtl/ais_pkg.sv */
// package with register map, field layout and decode tables of the block
package ais_pkg;

   // ************************************************************
   // register map and bus
   // ************************************************************
   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 32;
   localparam int          REG_W        = 8;
   localparam int          VIEW_W       = 16;
   localparam logic [7:0]  OFS_SEL      = 8'h00;
   localparam logic [7:0]  OFS_CTLB     = 8'h04;
   localparam logic [7:0]  OFS_RESULT   = 8'h08;
   localparam logic [7:0]  OFS_STATUS   = 8'h0c;
   localparam logic [7:0]  SEL_RESET    = 8'h00;
   localparam logic [7:0]  CTLB_RESET   = 8'h00;
   localparam logic [7:0]  CTLB_WMASK   = 8'hdf;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int          REF_B1_POS   = 7;
   localparam int          REF_B0_POS   = 6;
   localparam int          LADJ_POS     = 5;
   localparam int          MUXL_MSB     = 4;
   localparam int          GAIN_ALT_SELECT_POS     = 6;
   localparam int          REFH_POS     = 4;
   localparam int          MUXH_POS     = 3;
   localparam int          BUSY_POS     = 0;
   localparam int          DONE_POS     = 1;
   localparam int          LONG_POS     = 2;

   // ************************************************************
   // conversion timing and input codes
   // ************************************************************
   localparam int          LONG_CONV_CYCLES   = 25;
   localparam int          NORMAL_CONV_CYCLES = 13;
   localparam logic [5:0]  SE_LAST_CODE = 6'h0a;
   localparam logic [5:0]  BANDGAP_CODE = 6'h1e;
   localparam logic [5:0]  GROUND_CODE  = 6'h1f;
   localparam logic [5:0]  TEMP_CODE    = 6'h3f;
   localparam int          GBANK_POS    = 5;
   localparam int          HIGAIN_POS   = 8;

   typedef enum logic [2:0] {
      AIS_REF_SUPPLY  = 3'b000,
      AIS_REF_EXTPIN  = 3'b001,
      AIS_REF_INT11   = 3'b010,
      AIS_REF_RSVD    = 3'b011,
      AIS_REF_INT256  = 3'b100,
      AIS_REF_INT256C = 3'b101
   } ais_ref_e;

   typedef enum logic [1:0] {
      AIS_GAIN_1X  = 2'b00,
      AIS_GAIN_8X  = 2'b01,
      AIS_GAIN_20X = 2'b10,
      AIS_GAIN_32X = 2'b11
   } ais_gain_e;

   // per code: {high gain, positive channel, negative channel}
   localparam logic [8:0] MUX_TABLE [64] = '{
      9'h000, 9'h010, 9'h020, 9'h030, 9'h040, 9'h050, 9'h060, 9'h070,
      9'h080, 9'h090, 9'h0a0, 9'h101, 9'h001, 9'h111, 9'h121, 9'h021,
      9'h023, 9'h133, 9'h143, 9'h043, 9'h145, 9'h045, 9'h155, 9'h165,
      9'h065, 9'h189, 9'h089, 9'h199, 9'h1a9, 9'h0a9, 9'h000, 9'h000,
      9'h101, 9'h001, 9'h110, 9'h010, 9'h112, 9'h012, 9'h121, 9'h021,
      9'h120, 9'h020, 9'h102, 9'h002, 9'h145, 9'h045, 9'h154, 9'h054,
      9'h156, 9'h056, 9'h165, 9'h065, 9'h164, 9'h064, 9'h146, 9'h046,
      9'h100, 9'h000, 9'h111, 9'h122, 9'h144, 9'h155, 9'h166, 9'h0b0
   };

endpackage

/* rtl/ais_top.sv */
// register file, deferred shadows and input/reference decode of the adc
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Ref low bits 00 supply, 01 ext pin, high 0 with 10 1.1V, 11 reserved.
// - High ref bit set: 10 is 2.56V off the pin, 11 2.56V routed to the pin.
// - A reference write during a conversion waits for its completion.
// - Any reference change makes the next conversion long, 25 adc clocks.
// - Left adjust one aligns the 10-bit result left, zero aligns it right.
// - A left adjust change re-arranges the read result at once.
// - The six-bit input code is five select bits plus a top bit in ctrl B.
// - Differential codes also set the gain of the selected pair.
// - Codes tying one pin to both inputs are kept for offset measurement.
// - Codes 0-10 single-ended, 30 1.1V, 31 0V, 63 channel 11 plus sensor.
// - Gain alternate select gives 32x for 20x and 8x for 1x on differential codes 32-62 only.
// - A write to the top input code bit mid conversion waits for its end.
module ais_top
   import ais_pkg::*;
#(
   parameter int RES_W = 10
) (
   input  wire logic              core_clk,
   input  wire logic              rstn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              conv_busy,
   input  wire logic              conv_start,
   input  wire logic              conv_done,
   input  wire logic [RES_W-1:0]  conv_result,
   output ais_ref_e               ref_source,
   output logic                   ref_pin_connect,
   output logic                   int_ref_enable,
   output logic      [3:0]        pos_channel,
   output logic      [3:0]        neg_channel,
   output logic                   diff_mode,
   output ais_gain_e              gain,
   output logic                   bandgap_input,
   output logic                   ground_input,
   output logic                   temp_sensor_en,
   output logic                   long_conv_req
);

   // ************************************************************
   // reset release
   // ************************************************************
   logic [1:0] rst_pipe;
   logic       rst_n;

   // two-stage release of the asynchronous reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // ************************************************************
   // apb decode
   // ************************************************************
   logic mapped;
   logic wr_acc;
   logic wr_sel;
   logic wr_ctlb;
   logic wr_stat;

   // zero wait states; unmapped access errors
   always_comb begin
      mapped  = (paddr == OFS_SEL) || (paddr == OFS_CTLB) ||
                (paddr == OFS_RESULT) || (paddr == OFS_STATUS);
      pready  = 1'b1;
      pslverr = psel & penable & ~mapped;
      wr_acc  = psel & penable & pwrite & pstrb[0];
      wr_sel  = wr_acc & (paddr == OFS_SEL);
      wr_ctlb = wr_acc & (paddr == OFS_CTLB);
      wr_stat = wr_acc & (paddr == OFS_STATUS);
   end

   // ************************************************************
   // software registers
   // ************************************************************
   logic [REG_W-1:0] adc_input_select_reg;
   logic [REG_W-1:0] adc_control_b;
   logic [RES_W-1:0] result;
   logic             conversion_done_flag;
   logic [REG_W-1:0] next_adc_input_select_reg;
   logic [REG_W-1:0] next_adc_control_b;
   logic [RES_W-1:0] next_result;
   logic             next_conversion_done_flag;
   logic             left_adjust;
   logic             gain_alt_select;

   // register writes, result capture, done flag with set over clear
   always_comb begin
      next_adc_input_select_reg = adc_input_select_reg;
      next_adc_control_b        = adc_control_b;
      next_result               = result;
      if (wr_sel) begin
         next_adc_input_select_reg = pwdata[REG_W-1:0];
      end
      if (wr_ctlb) begin
         next_adc_control_b = pwdata[REG_W-1:0] & CTLB_WMASK;
      end
      if (conv_done) begin
         next_result = conv_result;
      end
      next_conversion_done_flag = conv_done |
         (conversion_done_flag & ~(wr_stat & pwdata[DONE_POS]));
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         adc_input_select_reg <= SEL_RESET;
         adc_control_b        <= CTLB_RESET;
         result               <= '0;
         conversion_done_flag <= 1'b0;
      end else begin
         adc_input_select_reg <= next_adc_input_select_reg;
         adc_control_b        <= next_adc_control_b;
         result               <= next_result;
         conversion_done_flag <= next_conversion_done_flag;
      end
   end

   assign left_adjust     = adc_input_select_reg[LADJ_POS];
   assign gain_alt_select = adc_control_b[GAIN_ALT_SELECT_POS];

   // ************************************************************
   // result presentation
   // ************************************************************
   logic [VIEW_W-1:0] result_view;

   // alignment follows the live adjust bit, not the shadow
   always_comb begin
      if (left_adjust) begin
         result_view = {result, {(VIEW_W-RES_W){1'b0}}};
      end else begin
         result_view = {{(VIEW_W-RES_W){1'b0}}, result};
      end
   end

   // ************************************************************
   // shadows and front-end decode
   // ************************************************************
   logic [2:0]  shadow_ref;
   logic [5:0]  shadow_code;
   logic        long_pend;
   logic        load;
   logic [2:0]  next_shadow_ref;
   logic [5:0]  next_shadow_code;
   logic        next_long_pend;
   logic [8:0]  entry;
   ais_ref_e    next_ref_source;
   logic        next_ref_pin;
   logic        next_int_ref;
   logic [3:0]  next_pos;
   logic [3:0]  next_neg;
   logic        next_diff;
   ais_gain_e   next_gain;
   logic        next_bandgap;
   logic        next_ground;
   logic        next_temp;

   // shadow load while idle or on completion, then decode the shadow
   always_comb begin
      load             = ~conv_busy | conv_done;
      next_shadow_ref  = shadow_ref;
      next_shadow_code = shadow_code;
      if (load) begin
         next_shadow_ref  = {adc_control_b[REFH_POS],
                             adc_input_select_reg[REF_B1_POS:REF_B0_POS]};
         next_shadow_code = {adc_control_b[MUXH_POS],
                             adc_input_select_reg[MUXL_MSB:0]};
      end
      // a reference change arms one long conversion; set wins
      next_long_pend = (next_shadow_ref != shadow_ref) |
                       (long_pend & ~conv_start);
      // reference source
      next_ref_pin = 1'b0;
      next_int_ref = 1'b0;
      unique casez (next_shadow_ref)
         3'b?00: next_ref_source = AIS_REF_SUPPLY;
         3'b?01: next_ref_source = AIS_REF_EXTPIN;
         3'b010: begin
            next_ref_source = AIS_REF_INT11;
            next_int_ref    = 1'b1;
         end
         3'b011: next_ref_source = AIS_REF_RSVD;
         3'b110: begin
            next_ref_source = AIS_REF_INT256;
            next_int_ref    = 1'b1;
         end
         default: begin
            next_ref_source = AIS_REF_INT256C;
            next_int_ref    = 1'b1;
         end
      endcase
      if (next_ref_source == AIS_REF_EXTPIN ||
          next_ref_source == AIS_REF_INT256C) begin
         next_ref_pin = 1'b1;
      end
      // input multiplexer and gain
      entry        = MUX_TABLE[next_shadow_code];
      next_pos     = entry[7:4];
      next_neg     = entry[3:0];
      next_diff    = 1'b0;
      next_gain    = AIS_GAIN_1X;
      next_bandgap = 1'b0;
      next_ground  = 1'b0;
      next_temp    = 1'b0;
      if (next_shadow_code <= SE_LAST_CODE) begin
         next_neg = '0;
      end else if (next_shadow_code == TEMP_CODE) begin
         next_neg  = '0;
         next_temp = 1'b1;
      end else if (next_shadow_code == BANDGAP_CODE) begin
         next_bandgap = 1'b1;
      end else if (next_shadow_code == GROUND_CODE) begin
         next_ground = 1'b1;
      end else begin
         next_diff = 1'b1;
         if (!next_shadow_code[GBANK_POS]) begin
            next_gain = entry[HIGAIN_POS] ? AIS_GAIN_20X : AIS_GAIN_1X;
         end else if (entry[HIGAIN_POS]) begin
            next_gain = gain_alt_select ? AIS_GAIN_32X : AIS_GAIN_20X;
         end else begin
            next_gain = gain_alt_select ? AIS_GAIN_8X : AIS_GAIN_1X;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow_ref      <= 3'b000;
         shadow_code     <= 6'h00;
         long_pend       <= 1'b0;
         ref_source      <= AIS_REF_SUPPLY;
         ref_pin_connect <= 1'b0;
         int_ref_enable  <= 1'b0;
         pos_channel     <= 4'h0;
         neg_channel     <= 4'h0;
         diff_mode       <= 1'b0;
         gain            <= AIS_GAIN_1X;
         bandgap_input   <= 1'b0;
         ground_input    <= 1'b0;
         temp_sensor_en  <= 1'b0;
      end else begin
         shadow_ref      <= next_shadow_ref;
         shadow_code     <= next_shadow_code;
         long_pend       <= next_long_pend;
         ref_source      <= next_ref_source;
         ref_pin_connect <= next_ref_pin;
         int_ref_enable  <= next_int_ref;
         pos_channel     <= next_pos;
         neg_channel     <= next_neg;
         diff_mode       <= next_diff;
         gain            <= next_gain;
         bandgap_input   <= next_bandgap;
         ground_input    <= next_ground;
         temp_sensor_en  <= next_temp;
      end
   end
   assign long_conv_req = long_pend;

   // ************************************************************
   // read data
   // ************************************************************
   logic [DATA_W-1:0] next_prdata;

   // read value captured in the setup cycle
   always_comb begin
      next_prdata = prdata;
      if (psel & ~penable & ~pwrite) begin
         next_prdata = '0;
         unique case (paddr)
            OFS_SEL:    next_prdata[REG_W-1:0]  = adc_input_select_reg;
            OFS_CTLB:   next_prdata[REG_W-1:0]  = adc_control_b;
            OFS_RESULT: next_prdata[VIEW_W-1:0] = result_view;
            OFS_STATUS: begin
               next_prdata[BUSY_POS] = conv_busy;
               next_prdata[DONE_POS] = conversion_done_flag;
               next_prdata[LONG_POS] = long_pend;
            end
            default:    next_prdata = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= '0;
      end else begin
         prdata <= next_prdata;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   property p_ref_supply;
      @(posedge core_clk) disable iff (!rst_n)
      (next_shadow_ref[1:0] == 2'b00) |=>
         (ref_source == AIS_REF_SUPPLY) && !ref_pin_connect;
   endproperty
   a_ref_supply: assert property (p_ref_supply)
      else $error("supply reference decode wrong");

   property p_ref_cap;
      @(posedge core_clk) disable iff (!rst_n)
      (next_shadow_ref == 3'b111) |=>
         (ref_source == AIS_REF_INT256C) && ref_pin_connect && int_ref_enable;
   endproperty
   a_ref_cap: assert property (p_ref_cap)
      else $error("bypassed 2.56V reference decode wrong");

   property p_ref_hold;
      @(posedge core_clk) disable iff (!rst_n)
      (conv_busy && !conv_done) |=> $stable(ref_source);
   endproperty
   a_ref_hold: assert property (p_ref_hold)
      else $error("reference changed during conversion");

   property p_long_arm;
      @(posedge core_clk) disable iff (!rst_n)
      (load && next_shadow_ref != shadow_ref) |=> long_conv_req;
   endproperty
   a_long_arm: assert property (p_long_arm)
      else $error("long conversion not armed");

   property p_left_view;
      @(posedge core_clk) disable iff (!rst_n)
      left_adjust |-> result_view[VIEW_W-1 -: RES_W] == result;
   endproperty
   a_left_view: assert property (p_left_view)
      else $error("left adjusted view wrong");

   property p_temp;
      @(posedge core_clk) disable iff (!rst_n)
      (next_shadow_code == TEMP_CODE) |=>
         temp_sensor_en && !diff_mode && pos_channel == 4'hb;
   endproperty
   a_temp: assert property (p_temp)
      else $error("temperature channel decode wrong");

   property p_gain32;
      @(posedge core_clk) disable iff (!rst_n)
      (next_diff && next_shadow_code[GBANK_POS] && entry[HIGAIN_POS] &&
       gain_alt_select) |=> gain == AIS_GAIN_32X;
   endproperty
   a_gain32: assert property (p_gain32)
      else $error("alternate gain not applied");

   property p_msb_hold;
      @(posedge core_clk) disable iff (!rst_n)
      (conv_busy && !conv_done) |=> $stable(shadow_code[5]);
   endproperty
   a_msb_hold: assert property (p_msb_hold)
      else $error("top input code bit changed mid conversion");

   property p_idle_load;
      @(posedge core_clk) disable iff (!rst_n)
      !conv_busy |=> shadow_code == {$past(adc_control_b[MUXH_POS]),
                                     $past(adc_input_select_reg[MUXL_MSB:0])};
   endproperty
   a_idle_load: assert property (p_idle_load)
      else $error("shadow not loaded while idle");

endmodule

`default_nettype wire

/* sim/ais_top_bench.sv */
// self-checking bench driving the input and reference select block over apb
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module ais_top_bench
   import ais_pkg::*;
;
   logic              core_clk;
   logic              rstn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [3:0]        pstrb;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic              conv_busy;
   logic              conv_start;
   logic              conv_done;
   logic [9:0]        conv_result;
   ais_ref_e          ref_source;
   logic              ref_pin_connect;
   logic              int_ref_enable;
   logic [3:0]        pos_channel;
   logic [3:0]        neg_channel;
   logic              diff_mode;
   ais_gain_e         gain;
   logic              bandgap_input;
   logic              ground_input;
   logic              temp_sensor_en;
   logic              long_conv_req;
   logic [DATA_W-1:0] rd;
   logic              err;
   logic [2:0]        r;
   logic [2:0]        er;
   logic [5:0]        c;
   logic              dif;
   logic [8:0]        t;
   logic [1:0]        eg;
   int                fail_count;
   int                checks;
   int                cyc;

   ais_top ais_top_i (
      .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_busy(conv_busy), .conv_start(conv_start),
      .conv_done(conv_done), .conv_result(conv_result),
      .ref_source(ref_source), .ref_pin_connect(ref_pin_connect),
      .int_ref_enable(int_ref_enable), .pos_channel(pos_channel),
      .neg_channel(neg_channel), .diff_mode(diff_mode), .gain(gain),
      .bandgap_input(bandgap_input), .ground_input(ground_input),
      .temp_sensor_en(temp_sensor_en), .long_conv_req(long_conv_req)
   );

   // ************************************************************
   // clock, timeout and verdict
   // ************************************************************
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // hang guard, well above the roughly 1350 cycles the tests need
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end

   // ************************************************************
   // bus and converter tasks
   // ************************************************************
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // hold the request until pready is seen high; if it never is, only the hang guard ends it
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      `CHK(pready, 1'b1)
      `CHK(rd, e)
      `CHK(err, 1'b0)
   endtask

   // idle cycles, then step past the edge so outputs are settled
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // one-cycle start (s=1) or done (s=0) strobe from the core
   task automatic pulse(input logic s);
      @(posedge core_clk);
      if (s) conv_start <= 1'b1;
      else conv_done <= 1'b1;
      @(posedge core_clk);
      conv_start <= 1'b0;
      conv_done  <= 1'b0;
   endtask

   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; pstrb = 4'hf; conv_busy = 1'b0;
      conv_start = 1'b0; conv_done = 1'b0; conv_result = 10'h000;
      fail_count = 0; checks = 0; cyc = 0;
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      idle(3);
      // reset state of registers and decode
      rd_chk(OFS_SEL, 32'h0);
      rd_chk(OFS_CTLB, 32'h0);
      `CHK(ref_source, AIS_REF_SUPPLY)
      `CHK(long_conv_req, 1'b0)
      $display("test reset done");

      // every reference code, with long request set and cleared
      for (int i = 0; i < 8; i++) begin
         r = 3'(i);
         wr(OFS_SEL, {24'h0, r[1:0], 6'h00});
         wr(OFS_CTLB, {27'h0, r[2], 4'h0});
         idle(3);
         er = r[1] ? {r[2], ~r[2], r[0]} : {1'b0, r[1:0]};
         `CHK(ref_source, ais_ref_e'(er))
         `CHK(ref_pin_connect, r[1:0] == 2'b01 || r == 3'b111)
         `CHK(int_ref_enable, r == 3'b010 || r[2:1] == 2'b11)
         `CHK(long_conv_req, i != 0)
         // start a conversion after each change so that it is the long one
         pulse(1'b1);
         idle(2);
         `CHK(long_conv_req, 1'b0)
      end
      $display("test reference decode done");

      // all input codes with gain alternate select off and on
      for (int g = 0; g < 2; g++) begin
         for (int j = 0; j < 64; j++) begin
            c = 6'(j);
            t = MUX_TABLE[j];
            dif = (j >= 11 && j <= 29) || (j >= 32 && j <= 62);
            wr(OFS_CTLB, {25'h0, g[0], 2'b00, c[5], 3'b000});
            wr(OFS_SEL, {27'h0, c[4:0]});
            idle(3);
            `CHK(diff_mode, dif)
            `CHK(pos_channel, t[7:4])
            `CHK(neg_channel, t[3:0])
            eg = dif ? {t[8], g[0] & c[5]} : 2'b00;
            `CHK(gain, ais_gain_e'(eg))
            `CHK(bandgap_input, j == 30)
            `CHK(ground_input, j == 31)
            `CHK(temp_sensor_en, j == 63)
         end
      end
      rd_chk(OFS_SEL, 32'h1f);
      rd_chk(OFS_CTLB, 32'h48);
      $display("test input decode done");

      // changes while busy wait for conversion done
      wr(OFS_SEL, 32'h0);
      wr(OFS_CTLB, 32'h0);
      pulse(1'b1);
      @(posedge core_clk);
      conv_busy <= 1'b1;
      wr(OFS_SEL, 32'h85);
      wr(OFS_CTLB, 32'h18);
      idle(3);
      `CHK(ref_source, AIS_REF_SUPPLY)
      `CHK(pos_channel, 4'h0)
      `CHK(long_conv_req, 1'b0)
      @(posedge core_clk);
      // core model hands back a fixed code, so reference settling never skews it
      conv_result <= 10'h2a5;
      pulse(1'b0);
      idle(2);
      `CHK(ref_source, AIS_REF_INT256)
      `CHK(pos_channel, 4'h1)
      `CHK(neg_channel, 4'h2)
      `CHK(long_conv_req, 1'b1)
      rd_chk(OFS_RESULT, 32'h2a5);
      rd_chk(OFS_STATUS, 32'h7);
      $display("test deferred load done");

      // left adjust takes effect at once while still busy
      wr(OFS_SEL, 32'ha5);
      rd_chk(OFS_RESULT, 32'ha940);
      wr(OFS_SEL, 32'h85);
      rd_chk(OFS_RESULT, 32'h2a5);
      wr(OFS_STATUS, 32'h2);
      rd_chk(OFS_STATUS, 32'h5);
      @(posedge core_clk);
      conv_busy <= 1'b0;
      $display("test alignment done");

      // unmapped address answers with an error
      xfer(8'h10, 1'b0, 32'h0);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h0)
      xfer(8'h10, 1'b1, 32'hff);
      `CHK(err, 1'b1)
      $display("test unmapped done");
      give_verdict();
   end

endmodule

`default_nettype wire
